// ---- mus_pkg.sv ----
// scaling parameter bank constants: offsets, resets, limits
// assumes a single 10 MHz clock domain and a parameter-map register port
// Notes on behaviour
// - convert user units to internal and back
// - ratio change reinterprets parameters, stores untouched
// - position ratio is revolutions over user units
// - position ratio applied only on numerator write
// - factory position ratio one rev per 16384
// - values accepted only from 1 to 2147483647
// - tiny position ratio confines movement to range
// - scaling writes accepted only with power disabled
// - velocity ratio is rpm over user units
// - velocity ratio applied on numerator write
// - factory velocity ratio one rpm per unit
// - ramp ratio is rpm/s over user units
// - ramp ratio applied on numerator write
// - factory ramp ratio one rpm/s per unit
package mus_pkg;
    // register offsets on the parameter map
    localparam logic [15:0] MUS_OFS_POS_BOT = 16'h060E;
    localparam logic [15:0] MUS_OFS_POS_TOP = 16'h0610;
    localparam logic [15:0] MUS_OFS_VEL_BOT = 16'h0642;
    localparam logic [15:0] MUS_OFS_VEL_TOP = 16'h0644;
    localparam logic [15:0] MUS_OFS_RMP_BOT = 16'h0660;
    localparam logic [15:0] MUS_OFS_RMP_TOP = 16'h0662;
    // factory values
    localparam logic [31:0] MUS_RST_POS_BOT = 32'h0000_4000;
    localparam logic [31:0] MUS_RST_POS_TOP = 32'h0000_0001;
    localparam logic [31:0] MUS_RST_VEL_BOT = 32'h0000_0001;
    localparam logic [31:0] MUS_RST_VEL_TOP = 32'h0000_0001;
    localparam logic [31:0] MUS_RST_RMP_BOT = 32'h0000_0001;
    localparam logic [31:0] MUS_RST_RMP_TOP = 32'h0000_0001;
    // accepted range
    localparam logic [31:0] MUS_MIN_VAL = 32'h0000_0001;
    localparam logic [31:0] MUS_MAX_VAL = 32'h7FFF_FFFF;
    // ratio threshold for confining movement: bottom > top * 131072
    localparam int MUS_CONFINE_SHIFT = 17;
    // movement range in user position units
    localparam logic signed [31:0] MUS_RANGE_LO = 32'shF000_0000;
    localparam logic signed [31:0] MUS_RANGE_HI = 32'sh0FFF_FFFF;
    // conversion engine
    localparam logic [5:0] MUS_DIV_STEPS = 6'h20;
    localparam logic [1:0] MUS_SEL_POS = 2'h0;
    localparam logic [1:0] MUS_SEL_VEL = 2'h1;
    localparam logic [1:0] MUS_SEL_RMP = 2'h2;
    // conversion engine states
    typedef enum logic [2:0] {
        MUS_CV_IDLE = 3'b001,
        MUS_CV_DIV = 3'b010,
        MUS_CV_DONE = 3'b100
    } mus_cv_state_e;
    // accepted value check
    function automatic logic mus_in_range(input logic [31:0] v);
        mus_in_range = (v >= MUS_MIN_VAL) && (v <= MUS_MAX_VAL);
    endfunction
endpackage

// ---- mus_ratio_slot.sv ----
// one scaling ratio: stored top and bottom plus the active pair
// assumes writes arrive as one-cycle strobes on the device clock
`timescale 1ns/100ps
module mus_ratio_slot (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // factory values
    input wire logic [31:0] rst_top,
    input wire logic [31:0] rst_bot,
    // write side
    input wire logic wr_top,
    input wire logic wr_bot,
    input wire logic [31:0] wdata,
    input wire logic power_on,
    // stored and active values
    output logic [31:0] top_r,
    output logic [31:0] bot_r,
    output logic [31:0] act_top_r,
    output logic [31:0] act_bot_r,
    output logic refused_r
);
    import mus_pkg::*;
    logic ok;
    // write accepted only when power is off and value in range
    assign ok = !power_on && mus_in_range(wdata);
    // stored values
    always_ff @(posedge clk) begin
        if (rst) begin
            top_r <= rst_top;
            bot_r <= rst_bot;
        end else if (ce) begin
            if (wr_top && ok) begin
                top_r <= wdata;
            end
            if (wr_bot && ok) begin
                bot_r <= wdata;
            end
        end
    end
    // active pair follows only an accepted top write
    always_ff @(posedge clk) begin
        if (rst) begin
            act_top_r <= rst_top;
            act_bot_r <= rst_bot;
        end else if (ce && wr_top && ok) begin
            act_top_r <= wdata;
            act_bot_r <= bot_r;
        end
    end
    // sticky refusal flag, cleared by next accepted write
    always_ff @(posedge clk) begin
        if (rst) begin
            refused_r <= 1'b0;
        end else if (ce && (wr_top || wr_bot)) begin
            refused_r <= !ok;
        end
    end
endmodule // mus_ratio_slot

// ---- mus_divider.sv ----
// unsigned 64 by 32 restoring divider, 32 quotient bits
// assumes the quotient fits 32 bits; the caller makes no overflow check
`timescale 1ns/100ps
module mus_divider (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // request
    input wire logic start,
    input wire logic [63:0] dividend,
    input wire logic [31:0] divisor,
    // answer
    output logic busy_r,
    output logic done_r,
    output logic [31:0] quot_r
);
    import mus_pkg::*;
    logic [63:0] rem_r; // partial remainder
    logic [63:0] num_r; // dividend being shifted out
    logic [5:0] cnt_r; // steps left
    logic [64:0] trial; // shifted remainder
    assign trial = {rem_r, num_r[63]};
    // one quotient bit per cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            quot_r <= 32'h0000_0000;
            rem_r <= 64'h0;
            num_r <= 64'h0;
            cnt_r <= 6'h00;
        end else if (ce) begin
            done_r <= 1'b0;
            if (start && !busy_r) begin
                busy_r <= 1'b1;
                rem_r <= {32'h0000_0000, dividend[63:32]};
                num_r <= {dividend[31:0], 32'h0000_0000};
                quot_r <= 32'h0000_0000;
                cnt_r <= MUS_DIV_STEPS;
            end else if (busy_r) begin
                if (trial[63:0] >= {32'h0000_0000, divisor}) begin
                    rem_r <= trial[63:0] - {32'h0000_0000, divisor};
                    quot_r <= {quot_r[30:0], 1'b1};
                end else begin
                    rem_r <= trial[63:0];
                    quot_r <= {quot_r[30:0], 1'b0};
                end
                num_r <= {num_r[62:0], 1'b0};
                cnt_r <= cnt_r - 6'h01;
                if (cnt_r == 6'h01) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end
endmodule // mus_divider

// ---- mus_scaling_bank.sv ----
// scaling bank: three ratio slots, parameter-map port, converter
// assumes a single-cycle parameter write/read port from the fieldbus side
`timescale 1ns/100ps
module mus_scaling_bank (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // power stage state, from an external pin
    input wire logic power_stage_en,
    // parameter-map port
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_addr,
    input wire logic [31:0] par_wdata,
    output logic [31:0] par_rdata_r,
    output logic par_ack_r,
    output logic par_err_r,
    // conversion request
    input wire logic cv_start,
    input wire logic [1:0] cv_sel,
    input wire logic cv_to_internal,
    input wire logic signed [31:0] cv_value,
    output logic signed [31:0] cv_result_r,
    output logic cv_done_r,
    output logic cv_busy_r,
    output logic cv_clamped_r,
    // status
    output logic pos_confined_r,
    output logic [2:0] ratio_changed_r
);
    import mus_pkg::*;

    // power pin synchroniser
    logic pw_s1_r; // first pin sample
    logic pw_s2_r; // second pin sample
    logic pw_s3_r; // third pin sample
    logic power_on_r; // settled power stage state
    // slot wiring
    logic [2:0] wr_top, wr_bot; // per-slot write strobes
    logic [31:0] top [3];
    logic [31:0] bot [3];
    logic [31:0] act_top [3];
    logic [31:0] act_bot [3];
    logic [31:0] prev_top [3];
    logic [31:0] prev_bot [3];
    logic hit;
    logic [31:0] rd_mux;
    // conversion engine
    mus_cv_state_e cv_state_r, cv_state_nxt;
    logic div_start, div_busy, div_done;
    logic [31:0] div_quot;
    logic [63:0] div_num;
    logic [31:0] div_den;
    logic neg_r;
    logic signed [32:0] signed_res;

    // three-stage pin sampling; change counts when stages 2 and 3 agree
    always_ff @(posedge clk) begin
        if (rst) begin
            pw_s1_r <= 1'b1;
            pw_s2_r <= 1'b1;
            pw_s3_r <= 1'b1;
            power_on_r <= 1'b1;
        end else if (ce) begin
            pw_s1_r <= power_stage_en;
            pw_s2_r <= pw_s1_r;
            pw_s3_r <= pw_s2_r;
            if (pw_s2_r == pw_s3_r) begin
                power_on_r <= pw_s3_r;
            end
        end
    end

    // address decode into slot strobes
    always_comb begin
        wr_top = 3'b000;
        wr_bot = 3'b000;
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (par_addr)
            MUS_OFS_POS_TOP: begin
                wr_top[0] = par_wr;
                rd_mux = top[0];
            end
            MUS_OFS_POS_BOT: begin
                wr_bot[0] = par_wr;
                rd_mux = bot[0];
            end
            MUS_OFS_VEL_TOP: begin
                wr_top[1] = par_wr;
                rd_mux = top[1];
            end
            MUS_OFS_VEL_BOT: begin
                wr_bot[1] = par_wr;
                rd_mux = bot[1];
            end
            MUS_OFS_RMP_TOP: begin
                wr_top[2] = par_wr;
                rd_mux = top[2];
            end
            MUS_OFS_RMP_BOT: begin
                wr_bot[2] = par_wr;
                rd_mux = bot[2];
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // position ratio: revolutions per user position units
    mus_ratio_slot u_pos (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .rst_top(MUS_RST_POS_TOP),
        .rst_bot(MUS_RST_POS_BOT),
        .wr_top(wr_top[0]),
        .wr_bot(wr_bot[0]),
        .wdata(par_wdata),
        .power_on(power_on_r),
        .top_r(top[0]),
        .bot_r(bot[0]),
        .act_top_r(act_top[0]),
        .act_bot_r(act_bot[0]),
        .refused_r() // refusal is reported by the port error pulse
    );
    // velocity ratio: rpm per user velocity units
    mus_ratio_slot u_vel (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .rst_top(MUS_RST_VEL_TOP),
        .rst_bot(MUS_RST_VEL_BOT),
        .wr_top(wr_top[1]),
        .wr_bot(wr_bot[1]),
        .wdata(par_wdata),
        .power_on(power_on_r),
        .top_r(top[1]),
        .bot_r(bot[1]),
        .act_top_r(act_top[1]),
        .act_bot_r(act_bot[1]),
        .refused_r() // refusal is reported by the port error pulse
    );
    // ramp ratio: rpm/s per user acceleration units
    mus_ratio_slot u_rmp (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .rst_top(MUS_RST_RMP_TOP),
        .rst_bot(MUS_RST_RMP_BOT),
        .wr_top(wr_top[2]),
        .wr_bot(wr_bot[2]),
        .wdata(par_wdata),
        .power_on(power_on_r),
        .top_r(top[2]),
        .bot_r(bot[2]),
        .act_top_r(act_top[2]),
        .act_bot_r(act_bot[2]),
        .refused_r() // refusal is reported by the port error pulse
    );

    // register port answer one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            par_rdata_r <= 32'h0000_0000;
            par_ack_r <= 1'b0;
            par_err_r <= 1'b0;
        end else if (ce) begin
            par_ack_r <= par_wr || par_rd;
            par_err_r <= 1'b0;
            if (par_rd) begin
                par_rdata_r <= hit ? rd_mux : 32'h0000_0000;
            end
            if ((par_wr && (!hit || power_on_r || !mus_in_range(par_wdata))) || (par_rd && !hit)) begin
                par_err_r <= 1'b1;
            end
        end
    end

    // ratio change pulse per slot; stored user values stay untouched
    always_ff @(posedge clk) begin
        if (rst) begin
            ratio_changed_r <= 3'b000;
            // start at the factory pairs so reset gives no false pulse
            prev_top[0] <= MUS_RST_POS_TOP;
            prev_bot[0] <= MUS_RST_POS_BOT;
            prev_top[1] <= MUS_RST_VEL_TOP;
            prev_bot[1] <= MUS_RST_VEL_BOT;
            prev_top[2] <= MUS_RST_RMP_TOP;
            prev_bot[2] <= MUS_RST_RMP_BOT;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                prev_top[i] <= act_top[i];
                prev_bot[i] <= act_bot[i];
                ratio_changed_r[i] <= (prev_top[i] != act_top[i]) || (prev_bot[i] != act_bot[i]);
            end
        end
    end

    // confinement flag when top/bottom < 1/131072
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_confined_r <= 1'b0;
        end else if (ce) begin
            pos_confined_r <= {17'h0, act_bot[0]} > ({17'h0, act_top[0]} << MUS_CONFINE_SHIFT);
        end
    end

    // operand selection: to internal = v*top/bot, to user = v*bot/top
    always_comb begin
        div_num = 64'h0;
        div_den = 32'h0000_0001;
        if (cv_sel <= MUS_SEL_RMP) begin
            if (cv_to_internal) begin
                div_num = 64'(cv_value[31] ? -cv_value : cv_value) * 64'(act_top[cv_sel]);
                div_den = act_bot[cv_sel];
            end else begin
                div_num = 64'(cv_value[31] ? -cv_value : cv_value) * 64'(act_bot[cv_sel]);
                div_den = act_top[cv_sel];
            end
        end
    end

    // converter state register
    always_ff @(posedge clk) begin
        if (rst) begin
            cv_state_r <= MUS_CV_IDLE;
        end else if (ce) begin
            cv_state_r <= cv_state_nxt;
        end
    end

    // converter next state
    always_comb begin
        cv_state_nxt = cv_state_r;
        div_start = 1'b0;
        case (cv_state_r)
            MUS_CV_IDLE: begin
                if (cv_start) begin
                    div_start = 1'b1;
                    cv_state_nxt = MUS_CV_DIV;
                end
            end
            MUS_CV_DIV: begin
                if (div_done) begin
                    cv_state_nxt = MUS_CV_DONE;
                end
            end
            MUS_CV_DONE: begin
                cv_state_nxt = MUS_CV_IDLE;
            end
            default: begin
                cv_state_nxt = MUS_CV_IDLE;
            end
        endcase
    end

    mus_divider u_div (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(div_start),
        .dividend(div_num),
        .divisor(div_den),
        .busy_r(div_busy),
        .done_r(div_done),
        .quot_r(div_quot)
    );

    // signed quotient
    assign signed_res = neg_r ? -$signed({1'b0, div_quot}) : $signed({1'b0, div_quot});

    // result register, confined position results to user units clamped to the movement range
    always_ff @(posedge clk) begin
        if (rst) begin
            cv_result_r <= 32'sh0000_0000;
            cv_done_r <= 1'b0;
            cv_busy_r <= 1'b0;
            cv_clamped_r <= 1'b0;
            neg_r <= 1'b0;
        end else if (ce) begin
            cv_done_r <= 1'b0;
            cv_busy_r <= (cv_state_nxt != MUS_CV_IDLE) || div_busy;
            if (div_start) begin
                neg_r <= cv_value[31];
            end
            if (cv_state_r == MUS_CV_DIV && div_done) begin
                cv_done_r <= 1'b1;
                cv_clamped_r <= 1'b0;
                cv_result_r <= signed_res[31:0];
                if (cv_sel == MUS_SEL_POS && !cv_to_internal && pos_confined_r) begin
                    if (signed_res > 33'(MUS_RANGE_HI)) begin
                        cv_result_r <= MUS_RANGE_HI;
                        cv_clamped_r <= 1'b1;
                    end else if (signed_res < 33'(MUS_RANGE_LO)) begin
                        cv_result_r <= MUS_RANGE_LO;
                        cv_clamped_r <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // mus_scaling_bank

// ---- mus_scaling_bank_checker.sv ----
// checker for the scaling bank: port timing and value relations
// assumes binding to mus_scaling_bank, one clock, sync active-high reset
`timescale 1ns/100ps
module mus_scaling_bank_checker (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire logic power_stage_en,
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_addr,
    input wire logic [31:0] par_wdata,
    input wire logic [31:0] par_rdata_r,
    input wire logic par_ack_r,
    input wire logic par_err_r,
    // converter
    input wire logic cv_start,
    input wire logic [1:0] cv_sel,
    input wire logic cv_to_internal,
    input wire logic signed [31:0] cv_value,
    input wire logic signed [31:0] cv_result_r,
    input wire logic cv_done_r,
    input wire logic cv_busy_r,
    input wire logic cv_clamped_r,
    // status
    input wire logic pos_confined_r,
    input wire logic [2:0] ratio_changed_r
);
    import mus_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // every request answered one cycle later
    property p_ack; ce && (par_wr || par_rd) |=> par_ack_r; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    // zero or negative values refused
    property p_range; ce && par_wr && (par_wdata == 32'h0 || par_wdata[31]) |=> par_err_r && par_ack_r; endproperty
    a_range: assert property (p_range) else $error("bad value taken");
    // writes refused while the power stage stays enabled
    property p_power; (power_stage_en [*6] ##0 (ce && par_wr)) |=> par_err_r; endproperty
    a_power: assert property (p_power) else $error("write taken with power on");
    // ratio change pulses only after an accepted top write
    property p_chg_pos; ratio_changed_r[0] |-> $past(par_wr && par_addr == MUS_OFS_POS_TOP, 2) && !$past(par_err_r); endproperty
    a_chg_pos: assert property (p_chg_pos) else $error("position change w/o top");
    property p_chg_vel; ratio_changed_r[1] |-> $past(par_wr && par_addr == MUS_OFS_VEL_TOP, 2) && !$past(par_err_r); endproperty
    a_chg_vel: assert property (p_chg_vel) else $error("velocity change w/o top");
    property p_chg_rmp; ratio_changed_r[2] |-> $past(par_wr && par_addr == MUS_OFS_RMP_TOP, 2) && !$past(par_err_r); endproperty
    a_chg_rmp: assert property (p_chg_rmp) else $error("ramp change w/o top");
    // conversion finishes a fixed 34 cycles after start
    property p_done; ce && cv_start && !cv_busy_r && !cv_done_r |-> ##34 cv_done_r; endproperty
    a_done: assert property (p_done) else $error("conversion late");
    // busy from the cycle after start until the cycle after done
    property p_busy; ce && cv_start && !cv_busy_r && !cv_done_r |=> cv_busy_r ##34 !cv_busy_r; endproperty
    a_busy: assert property (p_busy) else $error("busy flag wrong");
    // confined position results stay inside the movement range
    property p_conf; cv_done_r && pos_confined_r && cv_sel == MUS_SEL_POS && !cv_to_internal
        |-> cv_result_r >= MUS_RANGE_LO && cv_result_r <= MUS_RANGE_HI; endproperty
    a_conf: assert property (p_conf) else $error("result outside range");
    // clamp flag only on bounds of a confined position result
    property p_clamp; cv_done_r && cv_clamped_r |-> pos_confined_r && cv_sel == MUS_SEL_POS
        && (cv_result_r == MUS_RANGE_LO || cv_result_r == MUS_RANGE_HI); endproperty
    a_clamp: assert property (p_clamp) else $error("clamp flag wrong");
endmodule // mus_scaling_bank_checker
bind mus_scaling_bank mus_scaling_bank_checker mus_scaling_bank_checker_inst (.clk, .rst, .ce, .power_stage_en,
    .par_wr, .par_rd, .par_addr, .par_wdata, .par_rdata_r, .par_ack_r, .par_err_r, .cv_start, .cv_sel,
    .cv_to_internal, .cv_value, .cv_result_r, .cv_done_r, .cv_busy_r, .cv_clamped_r, .pos_confined_r,
    .ratio_changed_r);

// ---- mus_scaling_bank_tb_top.sv ----
// testbench for the scaling bank: register port and converter
// assumes package, design and checker compiled first
`timescale 1ns/100ps
module mus_scaling_bank_tb_top;
    import mus_pkg::*;
    typedef logic [33:0] mus_exp_t;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, power_stage_en = 1'b0;
    logic par_wr = 1'b0, par_rd = 1'b0, cv_start = 1'b0, cv_to_internal = 1'b0;
    logic [15:0] par_addr = 16'h0;
    logic [31:0] par_wdata = 32'h0, par_rdata_r;
    logic [1:0] cv_sel = 2'h0;
    logic signed [31:0] cv_value = 32'sh0, cv_result_r;
    logic par_ack_r, par_err_r, cv_done_r, cv_busy_r, cv_clamped_r, pos_confined_r;
    logic [2:0] ratio_changed_r;
    int n_mismatch = 0, checks_done = 0;
    mus_exp_t reg_q[$], cv_q[$], chg_q[$]; // expected results, oldest first
    logic [31:0] mdl[7], act_t[3], act_b[3]; // stored and active values
    logic [15:0] ofs[7] = '{MUS_OFS_POS_BOT, MUS_OFS_POS_TOP, MUS_OFS_VEL_BOT, MUS_OFS_VEL_TOP,
        MUS_OFS_RMP_BOT, MUS_OFS_RMP_TOP, 16'h0612}; // last one unmapped
    always #50 clk = ~clk;
    mus_scaling_bank mus_scaling_bank_inst (.clk, .rst, .ce, .power_stage_en, .par_wr, .par_rd, .par_addr,
        .par_wdata, .par_rdata_r, .par_ack_r, .par_err_r, .cv_start, .cv_sel, .cv_to_internal, .cv_value,
        .cv_result_r, .cv_done_r, .cv_busy_r, .cv_clamped_r, .pos_confined_r, .ratio_changed_r);
    // verdict and end of run
    task automatic end_sim();
        n_mismatch += reg_q.size() + cv_q.size() + chg_q.size(); // notes never answered
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // register answer: error flag, and data on reads
    task automatic chk_reg(input mus_exp_t e);
        checks_done++;
        if (e[33] ? ({par_err_r, par_rdata_r} !== e[32:0]) : (par_err_r !== e[32])) begin
            n_mismatch++;
            $display("[ERR] %0t exp %h got %h", $time, e[32:0], {par_err_r, par_rdata_r});
        end
    endtask
    // conversion answer: confined, clamped, result
    task automatic chk_cv(input mus_exp_t e);
        checks_done++;
        if ({pos_confined_r, cv_clamped_r, cv_result_r} !== e) begin
            n_mismatch++;
            $display("[ERR] %0t exp %h got %h", $time, e, {pos_confined_r, cv_clamped_r, cv_result_r});
        end
    endtask
    // ratio change pulse: which slot took a new active pair
    task automatic chk_chg(input mus_exp_t e);
        checks_done++;
        if ({31'h0, ratio_changed_r} !== e) begin
            n_mismatch++;
            $display("[ERR] %0t exp %h got %h", $time, e, ratio_changed_r);
        end
    endtask
    // watcher: pop the oldest note whenever an answer shows
    always @(negedge clk) begin
        if (par_ack_r === 1'b1) begin
            chk_reg(reg_q.size() > 0 ? reg_q.pop_front() : 34'h3_FFFF_FFFF);
        end
        if (cv_done_r === 1'b1) begin
            chk_cv(cv_q.size() > 0 ? cv_q.pop_front() : 34'h3_FFFF_FFFF);
        end
        if (ratio_changed_r !== 3'b000) begin
            chk_chg(chg_q.size() > 0 ? chg_q.pop_front() : 34'h3_FFFF_FFFF);
        end
    end
    // one register access; strobe stays up for back-to-back use
    task automatic acc(input logic w, input int i, input logic [31:0] d);
        logic e;
        e = (i == 6) || (w && (power_stage_en || d == 32'h0 || d[31]));
        @(posedge clk);
        #1;
        par_wr = w;
        par_rd = !w;
        par_addr = ofs[i];
        par_wdata = d;
        reg_q.push_back({!w, e, mdl[i]});
        if (w && !e) begin
            mdl[i] = d;
            if (i % 2 == 1) begin
                if (act_t[i / 2] != d || act_b[i / 2] != mdl[i - 1]) begin
                    chg_q.push_back(34'(3'b001 << (i / 2)));
                end
                act_t[i / 2] = d;
                act_b[i / 2] = mdl[i - 1];
            end
        end
    endtask
    // one conversion with the active ratio, waited out
    task automatic conv(input int s, input logic ti, input logic signed [31:0] v);
        longint r;
        logic cl, cf;
        int k;
        cf = act_b[0] > (longint'(act_t[0]) << 17);
        r = ti ? longint'(v) * longint'(act_t[s]) / longint'(act_b[s])
            : longint'(v) * longint'(act_b[s]) / longint'(act_t[s]);
        cl = cf && s == 0 && !ti && (r < MUS_RANGE_LO || r > MUS_RANGE_HI);
        if (cl) begin
            r = (r < 0) ? MUS_RANGE_LO : MUS_RANGE_HI;
        end
        cv_q.push_back({cf, cl, r[31:0]});
        @(posedge clk);
        #1;
        par_wr = 1'b0;
        par_rd = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        cv_start = 1'b1;
        cv_sel = 2'(s);
        cv_to_internal = ti;
        cv_value = v;
        @(posedge clk);
        #1;
        cv_start = 1'b0;
        for (k = 0; k < 60 && cv_done_r !== 1'b1; k++) @(negedge clk);
        if (k == 60) begin
            n_mismatch++;
            end_sim();
        end
        repeat (2) @(posedge clk);
    endtask
    // power stage change, then let the synchroniser settle
    task automatic pwr(input logic p);
        @(posedge clk);
        #1;
        power_stage_en = p;
        repeat (8) @(posedge clk);
    endtask
    // main sequence
    initial begin
        logic [31:0] bad[3] = '{32'h0, 32'h8000_0000, 32'hFFFF_FFFF};
        void'($urandom(32'he7d5));
        mdl = '{MUS_RST_POS_BOT, MUS_RST_POS_TOP, MUS_RST_VEL_BOT, MUS_RST_VEL_TOP,
            MUS_RST_RMP_BOT, MUS_RST_RMP_TOP, 32'h0};
        act_t = '{MUS_RST_POS_TOP, MUS_RST_VEL_TOP, MUS_RST_RMP_TOP};
        act_b = '{MUS_RST_POS_BOT, MUS_RST_VEL_BOT, MUS_RST_RMP_BOT};
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 7; i++) acc(1'b0, i, 32'h0);
        conv(0, 1'b1, 32'sh0000_4000);
        for (int s = 0; s < 3; s++) conv(s, 1'b0, 32'sh0000_0025);
        for (int s = 0; s < 3; s++) begin
            acc(1'b1, 2 * s, ($urandom % 32'd1000) + 32'd1);
            conv(s, 1'b1, 32'sh0000_3000);
            acc(1'b1, 2 * s + 1, ($urandom % 32'd50) + 32'd1);
            acc(1'b0, 2 * s + 1, 32'h0);
            conv(s, 1'b1, 32'sh0000_3000 - $signed({1'b0, $urandom % 32'd9000}));
            conv(s, 1'b0, -32'sh0000_1234);
        end
        foreach (bad[k]) acc(1'b1, 2, bad[k]);
        acc(1'b1, 4, 32'h7FFF_FFFF);
        acc(1'b0, 4, 32'h0);
        acc(1'b1, 4, 32'h1);
        acc(1'b0, 2, 32'h0);
        conv(1, 1'b1, 32'sh0000_0100);
        pwr(1'b1);
        acc(1'b1, 3, 32'h5);
        acc(1'b0, 3, 32'h0);
        conv(1, 1'b1, 32'sh0000_0100);
        pwr(1'b0);
        acc(1'b1, 0, 32'd200000);
        acc(1'b1, 1, 32'h1);
        conv(0, 1'b0, 32'sh0000_07D0);
        conv(0, 1'b0, -32'sh0000_07D0);
        conv(0, 1'b0, 32'sh0000_0005);
        end_sim();
    end
endmodule // mus_scaling_bank_tb_top
